// ---- hw/accel_consts.svh ----
// Purpose: Register offsets, field positions and reset values of the
//          acceleration status and motion event register block.
// Assumes: Byte-addressed registers reached by the serial interface logic.
// Notes:   Definitions only; included by bare name.
`ifndef ACCEL_CONSTS_SVH
`define ACCEL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ACC_ADDR_ID 8'h0F
`define ACC_ADDR_CTRL1 8'h20
`define ACC_ADDR_FILT 8'h23
`define ACC_ADDR_STATUS 8'h27
`define ACC_ADDR_X 8'h29
`define ACC_ADDR_Y 8'h2B
`define ACC_ADDR_Z 8'h2D
`define ACC_ADDR_CFG1 8'h30
`define ACC_ADDR_SRC1 8'h31
`define ACC_ADDR_THS1 8'h32

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define ACC_CFG_COMBINE 7
`define ACC_CFG_LATCH 6
`define ACC_SRC_ACTIVE 6
`define ACC_ST_ALL_OVR 7
`define ACC_ST_ALL_AVL 3
`define ACC_CFG_RST 8'h00
`define ACC_THS_RST 7'h00
`define ACC_AXEN_RST 3'h7
`define ACC_SRC_RST 8'h00
`define ACC_UNMAPPED 8'h00
`define ACC_FILT_READ 8'h00

`endif

// ---- hw/accel_pkg.sv ----
// Purpose: Shared types of the acceleration register block.
// Assumes: Two's complement 8-bit axis samples.
// Notes:   Constants live in accel_consts.svh.
package accel_pkg;
  typedef logic [7:0] accel_byte_t;
  typedef logic signed [7:0] accel_sample_t;
  typedef logic [6:0] accel_thr_t;
  typedef logic [2:0] accel_axes_t;
endpackage

// ---- hw/accel_sense_if.sv ----
// Purpose: Carries samples, enables, read strobes and flags between the
//          register front end, the status tracker and the motion detector.
// Assumes: All signals on the one block clock.
// Notes:   Axis index 0 is X, 1 is Y, 2 is Z.
`timescale 1ns/1ps
`default_nettype none
interface accel_sense_if;
  import accel_pkg::*;
  logic new_set;
  accel_axes_t axis_en;
  accel_sample_t new_data [3];
  accel_sample_t sample [3];
  accel_axes_t axis_read;
  accel_axes_t avail;
  accel_axes_t ovr;
  logic all_avail;
  logic all_ovr;
  accel_byte_t cfg;
  accel_thr_t thr;
  logic src_read;
  accel_byte_t source;
  logic request;
  modport front (output new_set, axis_en, new_data, axis_read, cfg, thr, src_read,
    input sample, avail, ovr, all_avail, all_ovr, source, request);
  modport status (input new_set, axis_en, new_data, axis_read,
    output sample, avail, ovr, all_avail, all_ovr);
  modport det (input sample, cfg, thr, src_read, output source, request);
endinterface
`default_nettype wire

// ---- hw/accel_axis_status.sv ----
// Purpose: Holds the three axis samples and their available/overrun flags.
// Assumes: new_set is a one-cycle strobe carrying a full sample set.
// Notes:   A new sample in the cycle of a read wins, so no sample is lost.
`timescale 1ns/1ps
`default_nettype none
module accel_axis_status (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block-side carrier
  accel_sense_if.status sense
);
  import accel_pkg::*;

  accel_sample_t sample_ff [3];
  accel_sample_t nxt_sample [3];
  accel_axes_t avail_ff, nxt_avail, ovr_ff, nxt_ovr;
  logic all_avail_ff, nxt_all_avail, all_ovr_ff, nxt_all_ovr;
  logic all_read;

  // Next flag values; a new sample sets avail despite a same-cycle read, but that read clears ovr
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (sense.new_set && sense.axis_en[i])
      begin
        nxt_sample[i] = sense.new_data[i];
        nxt_avail[i] = 1'b1;
        nxt_ovr[i] = (avail_ff[i] && !sense.axis_read[i]) || ovr_ff[i];
        if (sense.axis_read[i])
        begin
          nxt_ovr[i] = 1'b0;
        end
      end
      else
      begin
        nxt_sample[i] = sample_ff[i];
        nxt_avail[i] = avail_ff[i] && !sense.axis_read[i];
        nxt_ovr[i] = ovr_ff[i] && !sense.axis_read[i];
      end
    end
    // Nothing left unread on any enabled axis
    all_read = (nxt_avail & sense.axis_en) == 3'h0;
    nxt_all_avail = (sense.new_set && (sense.axis_en != 3'h0))
      || (all_avail_ff && !all_read);
    nxt_all_ovr = (sense.new_set && ((sense.axis_en & avail_ff & ~sense.axis_read) != 3'h0))
      || (all_ovr_ff && !all_read);
  end

  // Flag and sample registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 3; i++)
      begin
        sample_ff[i] <= 8'sh00;
      end
      avail_ff <= 3'h0;
      ovr_ff <= 3'h0;
      all_avail_ff <= 1'b0;
      all_ovr_ff <= 1'b0;
    end
    else
    begin
      sample_ff <= nxt_sample;
      avail_ff <= nxt_avail;
      ovr_ff <= nxt_ovr;
      all_avail_ff <= nxt_all_avail;
      all_ovr_ff <= nxt_all_ovr;
    end
  end

  assign sense.sample = sample_ff;
  assign sense.avail = avail_ff;
  assign sense.ovr = ovr_ff;
  assign sense.all_avail = all_avail_ff;
  assign sense.all_ovr = all_ovr_ff;
endmodule
`default_nettype wire

// ---- hw/accel_motion_det.sv ----
// Purpose: First free-fall/wake-up detector: threshold compare, combine,
//          optional latching and the source register.
// Assumes: Compares the held axis samples every clock.
// Notes:   Magnitude of -128 is 128, which is always at or above threshold.
`timescale 1ns/1ps
`default_nettype none
`include "accel_consts.svh"
module accel_motion_det (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block-side carrier
  accel_sense_if.det sense
);
  import accel_pkg::*;

  accel_byte_t source_ff, nxt_source;
  logic [5:0] ev, en;
  logic active;
  logic [7:0] mag;

  // Unsigned magnitude of a signed sample
  function automatic logic [7:0] magnitude(input accel_sample_t s);
    magnitude = s[7] ? 8'(-s) : 8'(s);
  endfunction

  // Live events, combination and latch hold
  always_comb
  begin
    mag = 8'h00;
    en = sense.cfg[5:0];
    for (int i = 0; i < 3; i++)
    begin
      mag = magnitude(sense.sample[i]);
      ev[2*i+1] = mag >= {1'b0, sense.thr};
      ev[2*i] = mag < {1'b0, sense.thr};
    end
    ev = ev & en;
    if (sense.cfg[`ACC_CFG_COMBINE])
    begin
      active = (en != 6'h00) && ((ev | ~en) == 6'h3F);
    end
    else
    begin
      active = ev != 6'h00;
    end
    // A read releases the hold; a live event that same cycle reloads at once
    if (sense.cfg[`ACC_CFG_LATCH] && source_ff[`ACC_SRC_ACTIVE] && !sense.src_read)
    begin
      nxt_source = source_ff;
    end
    else
    begin
      nxt_source = {1'b0, active, ev};
    end
  end

  // Source register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      source_ff <= `ACC_SRC_RST;
    end
    else
    begin
      source_ff <= nxt_source;
    end
  end

  assign sense.source = source_ff;
  assign sense.request = source_ff[`ACC_SRC_ACTIVE];
endmodule
`default_nettype wire

// ---- hw/accel_regs.sv ----
// Purpose: Register front end of the acceleration status and motion event
//          block: decode, configuration storage, readback, read effects.
// Assumes: reg_rd/reg_wr strobes come from the serial interface logic on
//          clk; meas_* come from the measurement chain on clk.
// Notes:   Read data appears one clock after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "accel_consts.svh"
module accel_regs #(
  parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access from the serial interface logic
  input wire accel_pkg::accel_byte_t reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire accel_pkg::accel_byte_t reg_wdata,
  output accel_pkg::accel_byte_t reg_rdata_ff,
  output logic reg_rvalid_ff,
  // Measurement chain samples
  input wire logic meas_valid,
  input wire accel_pkg::accel_sample_t meas_x,
  input wire accel_pkg::accel_sample_t meas_y,
  input wire accel_pkg::accel_sample_t meas_z,
  // Outputs to the filter and interrupt routing
  output logic filter_recovery_ff,
  output logic event1_request_ff
);
  import accel_pkg::*;

  // --------------------------------------------------------------------------
  // Internal carrier and submodules
  // --------------------------------------------------------------------------
  accel_sense_if sense ();

  accel_axis_status u_status (
    .clk(clk),
    .rst(rst),
    .sense(sense.status)
  );

  accel_motion_det u_det (
    .clk(clk),
    .rst(rst),
    .sense(sense.det)
  );

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  accel_axes_t axis_en_ff, nxt_axis_en;
  accel_byte_t cfg_ff, nxt_cfg;
  accel_thr_t thr_ff, nxt_thr;
  accel_byte_t nxt_rdata;
  logic nxt_rvalid;
  logic nxt_filter_recovery;
  logic nxt_event1_request;
  accel_axes_t axis_read;
  logic src_read;

  // Address match helper, used by both the read and the write decode
  function automatic logic hit(input accel_byte_t a, input accel_byte_t b);
    hit = a == b;
  endfunction

  // --------------------------------------------------------------------------
  // Read side effects
  // --------------------------------------------------------------------------
  // Clears act on the strobe edge; the readback below still shows the
  // pre-clear value, so software never loses a flag it has not seen
  always_comb
  begin
    axis_read[0] = reg_rd && hit(reg_addr, `ACC_ADDR_X);
    axis_read[1] = reg_rd && hit(reg_addr, `ACC_ADDR_Y);
    axis_read[2] = reg_rd && hit(reg_addr, `ACC_ADDR_Z);
    src_read = reg_rd && hit(reg_addr, `ACC_ADDR_SRC1);
    nxt_filter_recovery = reg_rd && hit(reg_addr, `ACC_ADDR_FILT);
  end

  // --------------------------------------------------------------------------
  // Carrier connections
  // --------------------------------------------------------------------------
  // One strobe brings all three axes; the status block drops disabled ones
  assign sense.new_set = meas_valid;
  assign sense.axis_en = axis_en_ff;
  assign sense.new_data[0] = meas_x;
  assign sense.new_data[1] = meas_y;
  assign sense.new_data[2] = meas_z;
  assign sense.axis_read = axis_read;
  assign sense.cfg = cfg_ff;
  assign sense.thr = thr_ff;
  assign sense.src_read = src_read;

  // --------------------------------------------------------------------------
  // Configuration writes
  // --------------------------------------------------------------------------
  // Writes to read-only or unmapped addresses are dropped silently
  always_comb
  begin
    nxt_axis_en = axis_en_ff;
    nxt_cfg = cfg_ff;
    nxt_thr = thr_ff;
    if (reg_wr)
    begin
      if (hit(reg_addr, `ACC_ADDR_CTRL1))
      begin
        nxt_axis_en = reg_wdata[2:0];
      end
      if (hit(reg_addr, `ACC_ADDR_CFG1))
      begin
        nxt_cfg = reg_wdata;
      end
      if (hit(reg_addr, `ACC_ADDR_THS1))
      begin
        nxt_thr = reg_wdata[6:0];
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      axis_en_ff <= `ACC_AXEN_RST;
      cfg_ff <= `ACC_CFG_RST;
      thr_ff <= `ACC_THS_RST;
    end
    else
    begin
      axis_en_ff <= nxt_axis_en;
      cfg_ff <= nxt_cfg;
      thr_ff <= nxt_thr;
    end
  end

  // --------------------------------------------------------------------------
  // Readback
  // --------------------------------------------------------------------------
  // Data is only decoded on a read so the bus sees zero between accesses
  always_comb
  begin
    nxt_rvalid = reg_rd;
    nxt_rdata = `ACC_UNMAPPED;
    if (reg_rd)
    begin
      case (reg_addr)
        `ACC_ADDR_ID:
        begin
          nxt_rdata = PART_ID;
        end
        `ACC_ADDR_CTRL1:
        begin
          nxt_rdata = {5'h00, axis_en_ff};
        end
        `ACC_ADDR_FILT:
        begin
          nxt_rdata = `ACC_FILT_READ;
        end
        `ACC_ADDR_STATUS:
        begin
          nxt_rdata = {sense.all_ovr, sense.ovr, sense.all_avail, sense.avail};
        end
        `ACC_ADDR_X:
        begin
          nxt_rdata = sense.sample[0];
        end
        `ACC_ADDR_Y:
        begin
          nxt_rdata = sense.sample[1];
        end
        `ACC_ADDR_Z:
        begin
          nxt_rdata = sense.sample[2];
        end
        `ACC_ADDR_CFG1:
        begin
          nxt_rdata = cfg_ff;
        end
        `ACC_ADDR_SRC1:
        begin
          nxt_rdata = sense.source;
        end
        `ACC_ADDR_THS1:
        begin
          nxt_rdata = {1'b0, thr_ff};
        end
        default:
        begin
          nxt_rdata = `ACC_UNMAPPED;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  // The request is re-registered so every top output is a flop here; it
  // trails the source register by one clock, negligible at sample rates
  always_comb
  begin
    nxt_event1_request = sense.request;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_ff <= `ACC_UNMAPPED;
      reg_rvalid_ff <= 1'b0;
      filter_recovery_ff <= 1'b0;
      event1_request_ff <= 1'b0;
    end
    else
    begin
      reg_rdata_ff <= nxt_rdata;
      reg_rvalid_ff <= nxt_rvalid;
      filter_recovery_ff <= nxt_filter_recovery;
      event1_request_ff <= nxt_event1_request;
    end
  end
endmodule
`default_nettype wire

// ---- verification/accel_regs_sva.sv ----
// Purpose: Port-level checks of the acceleration register block.
// Assumes: Sees only the top module ports; one clock.
// Notes:   Bound into accel_regs after the module.
`timescale 1ns/1ps
`default_nettype none
`include "accel_consts.svh"
module accel_regs_sva #(
  parameter logic [7:0] PART_ID = 8'hA5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access
  input wire accel_pkg::accel_byte_t reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire accel_pkg::accel_byte_t reg_wdata,
  input wire accel_pkg::accel_byte_t reg_rdata_ff,
  input wire logic reg_rvalid_ff,
  // Block outputs
  input wire logic filter_recovery_ff,
  input wire logic event1_request_ff
);
  import accel_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Write then read of the same place, so readback ties to the written byte
  sequence s_cfg_wr_rd;
    (reg_wr && reg_addr == `ACC_ADDR_CFG1) ##1 (reg_rd && !reg_wr && reg_addr == `ACC_ADDR_CFG1);
  endsequence
  a_read_answer: assert property (reg_rd |=> reg_rvalid_ff)
    else $error("read got no answer");
  a_idle_quiet: assert property (!reg_rd |=> !reg_rvalid_ff && reg_rdata_ff == 8'h00)
    else $error("read data without a read");
  a_id_value: assert property (reg_rd && reg_addr == `ACC_ADDR_ID |=> reg_rdata_ff == PART_ID)
    else $error("identity value wrong");
  a_filter_pulse: assert property (reg_rd && reg_addr == `ACC_ADDR_FILT |=>
    filter_recovery_ff && reg_rdata_ff == `ACC_FILT_READ)
    else $error("filter recovery not pulsed");
  a_filter_only: assert property (!(reg_rd && reg_addr == `ACC_ADDR_FILT) |=> !filter_recovery_ff)
    else $error("filter recovery without its read");
  a_cfg_readback: assert property (s_cfg_wr_rd |=> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("config readback wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  a_thr_top_bit: assert property (reg_rd && reg_addr == `ACC_ADDR_THS1 |=> !reg_rdata_ff[7])
    else $error("threshold top bit set");
  c_status_read: cover property (reg_rd && reg_addr == `ACC_ADDR_STATUS);
  c_event_rise: cover property ($rose(event1_request_ff));
  c_filter_read: cover property (filter_recovery_ff);
endmodule
bind accel_regs accel_regs_sva #(.PART_ID(PART_ID)) u_sva (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
  .filter_recovery_ff(filter_recovery_ff), .event1_request_ff(event1_request_ff));
`default_nettype wire

// ---- verification/accel_host_model.sv ----
// Purpose: Host side of the register access, byte by byte.
// Assumes: Requests change 1 ns after a rising edge.
// Notes:   Released address and data are inverted so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module accel_host_model (
  // Clock
  input wire logic clk,
  // Register access towards the device
  output var accel_pkg::accel_byte_t reg_addr,
  output var logic reg_rd,
  output var logic reg_wr,
  output var accel_pkg::accel_byte_t reg_wdata,
  input wire accel_pkg::accel_byte_t reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  import accel_pkg::*;
  // Idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One byte write by byte address
  task automatic wr(input accel_byte_t a, input accel_byte_t d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Write then read of the same byte, back to back, so readback is seen at once
  task automatic wr_rd(input accel_byte_t a, input accel_byte_t d, output accel_byte_t q);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rvalid_ff ? reg_rdata_ff : 8'hXX;
  endtask
  // One byte read; answer registered at the taking edge
  task automatic rd(input accel_byte_t a, output accel_byte_t d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid_ff ? reg_rdata_ff : 8'hXX;
  endtask
endmodule
`default_nettype wire

// ---- verification/accel_regs_tb.sv ----
// Purpose: Self-checking bench of the acceleration register block.
// Assumes: 10 MHz clock; host model makes all register accesses.
// Notes:   Reset values run from a table; sample and event cases by hand.
`timescale 1ns/1ps
`default_nettype none
`include "accel_consts.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); bad_count++; end end
module accel_regs_tb;
  import accel_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h5C; // Arbitrary value
  localparam int NROW = 12;
  localparam logic [7:0] ROW_ADDR [NROW] = '{8'h0F, 8'h20, 8'h23, 8'h27, 8'h29, 8'h2B,
    8'h2D, 8'h30, 8'h31, 8'h32, 8'h00, 8'h28};
  localparam logic [7:0] ROW_EXP [NROW] = '{ID_VAL, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_rd;
  logic reg_wr;
  accel_byte_t reg_addr;
  accel_byte_t reg_wdata;
  accel_byte_t rdata;
  logic rvalid;
  logic meas_valid = 1'b0;
  accel_sample_t mx = 8'h00;
  accel_sample_t my = 8'h00;
  accel_sample_t mz = 8'h00;
  logic filt;
  logic evt;
  accel_byte_t q;
  int bad_count = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  accel_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid));
  accel_regs #(.PART_ID(ID_VAL)) u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_ff(rdata),
    .reg_rvalid_ff(rvalid), .meas_valid(meas_valid), .meas_x(mx), .meas_y(my), .meas_z(mz),
    .filter_recovery_ff(filt), .event1_request_ff(evt));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk_rd(input accel_byte_t a, input accel_byte_t e);
    accel_byte_t d;
    u_host.rd(a, d);
    `CHK(d, e)
  endtask
  // One sample set strobe
  task automatic meas(input accel_sample_t x, input accel_sample_t y, input accel_sample_t z);
    @(posedge clk);
    #1;
    meas_valid = 1'b1;
    mx = x;
    my = y;
    mz = z;
    @(posedge clk);
    #1;
    meas_valid = 1'b0;
  endtask
  // Bounded wait, rather than counting the two-clock request latency after a config write
  task automatic wait_evt(input logic e);
    for (int i = 0; i < 8 && evt !== e; i++)
      @(posedge clk);
    #1;
    `CHK(evt, e)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the 140 or so cycles the tests need
  initial
  begin
    #300000;
    bad_count++;
    conclude();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < NROW; i++)
      chk_rd(ROW_ADDR[i], ROW_EXP[i]);
    // Recovery pulse stands in the cycle the read data stands
    chk_rd(`ACC_ADDR_FILT, 8'h00);
    `CHK(filt, 1'b1)
    u_host.wr(`ACC_ADDR_ID, 8'h00);
    chk_rd(`ACC_ADDR_ID, ID_VAL);
    // Z disabled: it never updates nor flags
    u_host.wr(`ACC_ADDR_CTRL1, 8'h03);
    meas(8'h10, 8'hEC, 8'h30);
    chk_rd(`ACC_ADDR_STATUS, 8'h0B);
    chk_rd(`ACC_ADDR_X, 8'h10);
    chk_rd(`ACC_ADDR_STATUS, 8'h0A);
    chk_rd(`ACC_ADDR_Y, 8'hEC);
    chk_rd(`ACC_ADDR_STATUS, 8'h00);
    chk_rd(`ACC_ADDR_Z, 8'h00);
    u_host.wr(`ACC_ADDR_CTRL1, 8'h07);
    // Two unread sets overrun every axis
    meas(8'h01, 8'h02, 8'h03);
    meas(8'h04, 8'h05, 8'h06);
    chk_rd(`ACC_ADDR_STATUS, 8'hFF);
    chk_rd(`ACC_ADDR_X, 8'h04);
    chk_rd(`ACC_ADDR_STATUS, 8'hEE);
    chk_rd(`ACC_ADDR_Y, 8'h05);
    chk_rd(`ACC_ADDR_Z, 8'h06);
    chk_rd(`ACC_ADDR_STATUS, 8'h00);
    // Threshold is 7 bits; equal counts as high, one below as low
    u_host.wr(`ACC_ADDR_THS1, 8'h90);
    chk_rd(`ACC_ADDR_THS1, 8'h10);
    u_host.wr(`ACC_ADDR_CFG1, 8'h3F);
    meas(8'h10, 8'h0F, 8'h80);
    wait_evt(1'b1);
    chk_rd(`ACC_ADDR_SRC1, 8'h66);
    // AND of both directions on one axis can never hold
    u_host.wr(`ACC_ADDR_CFG1, 8'hBF);
    wait_evt(1'b0);
    u_host.wr(`ACC_ADDR_CFG1, 8'h89);
    meas(8'hFB, 8'h80, 8'h00);
    wait_evt(1'b1);
    meas(8'hFB, 8'h0F, 8'h00);
    wait_evt(1'b0);
    // Latched request outlives its cause until the source read
    u_host.wr(`ACC_ADDR_CFG1, 8'h42);
    meas(8'h20, 8'h00, 8'h00);
    wait_evt(1'b1);
    meas(8'h00, 8'h00, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    `CHK(evt, 1'b1)
    chk_rd(`ACC_ADDR_SRC1, 8'h42);
    wait_evt(1'b0);
    chk_rd(`ACC_ADDR_SRC1, 8'h00);
    // Config write followed at once by its read
    u_host.wr_rd(`ACC_ADDR_CFG1, 8'h5A, q);
    `CHK(q, 8'h5A)
    // Mid-run reset restores defaults
    u_host.wr(`ACC_ADDR_CTRL1, 8'h01);
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk_rd(`ACC_ADDR_CFG1, 8'h00);
    chk_rd(`ACC_ADDR_CTRL1, 8'h07);
    conclude();
  end
endmodule
`default_nettype wire
